/* File: logic/stepper_fault_chop.sv */
// Purpose: thermal and overcurrent shutdown latches plus chopper timing
// Assumes: all inputs synchronous to i_ref_clk; i_chop_osc is one tick per oscillator cycle
// Notes: standby low or reset clears every latch and counter except the blank counter, which reloads a full blank
import stepper_fault_pkg::*;

// How it works
// - overtemperature switches every bridge transistor off through internal reset.
// - thermal trip stays latched until standby low or power-on reset.
// - overcurrent trip switches outputs off and stops the chopping oscillator.
// - overcurrent must persist four oscillator ticks before it trips.
// - after release the block resumes normal running within four oscillator ticks.
// - a shorted output is switched off within eight oscillator ticks.
// - overcurrent trip stays latched until standby low or power-on reset.
// - while overcurrent trip is latched outputs idle as in standby.
// - current sensing is blanked for 400 ns after each switching event.
// - nominal 1600 kHz oscillator gives a nominal 100 kHz chopper.
// - chopper period is the oscillator divided by sixteen.
module stepper_fault_chop #(
  parameter int CHOP_DIV_P = stepper_fault_pkg::CHOP_DIV
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_standby_n,
  input wire logic i_chop_osc,
  input wire logic i_thermal_over,
  input wire logic i_over_current,
  input wire logic i_sense_over,
  output logic o_bridge_en,
  output logic o_chop_on,
  output logic o_osc_run,
  output logic o_thermal_trip,
  output logic o_overcurrent_trip
);
  import stepper_fault_pkg::*;

  fault_state_t state;
  fault_state_t next_state;
  logic [2:0] mask_cnt;
  logic [7:0] blank_cnt;
  logic chop_off;
  logic period_start;
  // assertion helpers: cycles since the last switching event, ticks inside the running period
  localparam int TW = $clog2(CHOP_DIV_P) + 1;
  localparam logic [7:0] BLANK_MIN_GAP = 8'(SENSE_BLANK_MIN_NS / CLK_PERIOD_NS);
  localparam logic [7:0] BLANK_MAX_GAP = 8'(SENSE_BLANK_MAX_NS / CLK_PERIOD_NS - 1);
  logic [7:0] since_switch;
  logic [TW-1:0] tick_seen;

  // standby low acts like the power-on reset for the whole fault logic
  wire clear = !i_rst_n || !i_standby_n;
  wire tick = i_chop_osc && o_osc_run;
  wire running = (state == ST_RUN);
  wire mask_done = running && i_over_current && tick && (mask_cnt == MASK_TICKS - 3'h1);
  wire sense_ok = running && (blank_cnt == 8'h00);
  wire chop_set = sense_ok && i_sense_over && !chop_off;
  wire switch_evt = period_start || chop_set;
  wire next_chop_off = period_start ? 1'b0 : (chop_off || chop_set);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = i_thermal_over ? ST_TH_TRIP : ST_RUN;
      ST_RUN: begin
        if (i_thermal_over) begin
          next_state = ST_TH_TRIP;
        end else if (mask_done) begin
          next_state = ST_OC_TRIP;
        end
      end
      ST_OC_TRIP: next_state = ST_OC_TRIP;
      ST_TH_TRIP: next_state = ST_TH_TRIP;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // outputs follow the next state so a trip shuts the bridge on the very next edge
  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      o_bridge_en <= 1'b0;
      o_chop_on <= 1'b0;
      o_osc_run <= 1'b1;
      o_thermal_trip <= 1'b0;
      o_overcurrent_trip <= 1'b0;
    end else begin
      o_bridge_en <= (next_state == ST_RUN);
      o_chop_on <= (next_state == ST_RUN) && !next_chop_off;
      o_osc_run <= (next_state != ST_OC_TRIP);
      // also latches on top of an overcurrent trip so a later overheat is not lost
      o_thermal_trip <= o_thermal_trip || i_thermal_over;
      o_overcurrent_trip <= (next_state == ST_OC_TRIP);
    end
  end

  // mask counter restarts whenever the overcurrent indication drops
  always_ff @(posedge i_ref_clk) begin
    if (clear || !i_over_current || !running) begin
      mask_cnt <= 3'h0;
    end else if (tick && mask_cnt < MASK_TICKS - 3'h1) begin
      mask_cnt <= mask_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      blank_cnt <= SENSE_BLANK_CYC;
    end else if (switch_evt) begin
      blank_cnt <= SENSE_BLANK_CYC;
    end else if (blank_cnt != 8'h00) begin
      blank_cnt <= blank_cnt - 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (clear) begin
      chop_off <= 1'b0;
    end else begin
      chop_off <= next_chop_off;
    end
  end

  // counted apart from the blank counter and the divider so that a fault in either
  // cannot hide itself from the checks below; saturates so a long idle never wraps
  always_ff @(posedge i_ref_clk) begin
    if (clear || switch_evt) begin
      since_switch <= 8'h00;
    end else if (since_switch != 8'hFF) begin
      since_switch <= since_switch + 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (clear || !running) begin
      tick_seen <= '0;
    end else if (period_start) begin
      tick_seen <= tick ? TW'(1) : '0;
    end else if (tick) begin
      tick_seen <= tick_seen + TW'(1);
    end
  end

  chop_divider #(
    .DIV(CHOP_DIV_P)
  ) u_div (
    .i_ref_clk(i_ref_clk),
    .i_clear(clear || !running),
    .i_tick(tick),
    .o_period_start(period_start)
  );

  a_thermal_shut_off: assert property (@(posedge i_ref_clk)
    (i_rst_n && i_standby_n && i_thermal_over) |=> (!o_bridge_en && !o_chop_on && o_thermal_trip))
    else $error("thermal trip did not switch bridge off");

  a_thermal_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == ST_TH_TRIP && i_standby_n && i_rst_n) |=> (state == ST_TH_TRIP && !o_bridge_en))
    else $error("thermal trip released without standby");

  a_oc_osc_stop: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == ST_OC_TRIP) |-> (!o_osc_run && o_overcurrent_trip))
    else $error("oscillator running during overcurrent trip");

  a_oc_mask_need: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (running && i_standby_n && !i_thermal_over && i_over_current && tick && mask_cnt < 3'h3)
    |=> (state == ST_RUN))
    else $error("overcurrent tripped before four ticks");

  a_oc_trip_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (running && i_standby_n && i_over_current && tick && mask_cnt == 3'h3) |=> (!o_bridge_en))
    else $error("short not switched off in time");

  a_oc_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == ST_OC_TRIP && i_standby_n && i_rst_n) |=> (state == ST_OC_TRIP))
    else $error("overcurrent trip released without standby");

  a_oc_idle_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == ST_OC_TRIP) |-> (!o_bridge_en && !o_chop_on))
    else $error("outputs active during overcurrent trip");

  a_blank_after_sw: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (switch_evt && i_standby_n) |=> (!chop_set) [*8])
    else $error("sense accepted inside blank time");

  a_chop_period_gap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    period_start |=> (!period_start) [*8])
    else $error("chopper periods too close");

  a_exit_resume: assert property (@(posedge i_ref_clk)
    (state == ST_IDLE && i_rst_n && i_standby_n && !i_thermal_over) |=> (running && o_bridge_en))
    else $error("did not resume after release");

  a_standby_clear: assert property (@(posedge i_ref_clk)
    (!i_standby_n) |=> (state == ST_IDLE && mask_cnt == 3'h0 && !o_overcurrent_trip))
    else $error("standby did not clear fault logic");

  // blank window bounds, judged against the free counter rather than the blank counter
  a_blank_min_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    chop_set |-> (since_switch >= BLANK_MIN_GAP))
    else $error("chop decision taken before blank minimum");

  a_blank_max_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (running && i_sense_over && !chop_off && since_switch >= BLANK_MAX_GAP) |-> chop_set)
    else $error("chop decision held off past blank maximum");

  a_period_ticks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    period_start |-> (tick_seen == TW'(CHOP_DIV_P)))
    else $error("chopper period tick count wrong");

  a_period_reopen: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (period_start && i_standby_n && next_state == ST_RUN) |=> o_chop_on)
    else $error("chopper period did not reopen charge phase");
endmodule

/* File: include/stepper_fault_pkg.sv */
// Purpose: shared constants and state codes for the fault and chopper timing block
// Assumes: 125 MHz reference clock; chopping oscillator arrives as a one-cycle tick
// Notes: times are kept in ns; the nominal blank is turned into clock counts here, the blank bounds in stepper_fault_chop
package stepper_fault_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SENSE_BLANK_NS = 400;
  localparam int SENSE_BLANK_MIN_NS = 300;
  localparam int SENSE_BLANK_MAX_NS = 500;
  // nominal blank, rounded up to whole clock cycles
  localparam int SENSE_BLANK_CYC_I = (SENSE_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SENSE_BLANK_CYC = 8'(SENSE_BLANK_CYC_I);
  localparam logic [2:0] MASK_TICKS = 3'h4;
  localparam int SHORT_OFF_TICKS = 8;
  localparam int EXIT_MAX_TICKS = 4;
  localparam int CHOP_DIV = 16;
  localparam int OSC_NOMINAL_KHZ = 1600;
  localparam int CHOP_NOMINAL_KHZ = OSC_NOMINAL_KHZ / CHOP_DIV;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_RUN     = 4'h2,
    ST_OC_TRIP = 4'h4,
    ST_TH_TRIP = 4'h8
  } fault_state_t;
endpackage

/* File: logic/chop_divider.sv */
// Purpose: divides chopping oscillator ticks into chopper periods
// Assumes: i_tick is a one-cycle pulse, synchronous to i_ref_clk
// Notes: o_period_start pulses once every DIV ticks
module chop_divider #(
  parameter int DIV = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_clear,
  input wire logic i_tick,
  output logic o_period_start
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count;
  wire wrap = i_tick && (count == LAST);

  always_ff @(posedge i_ref_clk) begin
    if (i_clear) begin
      count <= '0;
      o_period_start <= 1'b0;
    end else begin
      if (i_tick) begin
        count <= wrap ? '0 : count + W'(1);
      end
      o_period_start <= wrap;
    end
  end
endmodule

/* File: dv/stepper_controller_model.sv */
// Purpose: far-side model giving the chopping oscillator ticks
// Assumes: ticks are one-cycle pulses launched on the falling edge
// Notes: i_en follows o_osc_run, so ticks stop as a stopped oscillator would
module stepper_controller_model #(
  parameter int GAP = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_en,
  output logic o_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial o_tick = 1'b0;
  // pulses stay GAP cycles apart, so no level it drives is shorter than the minimum width
  always @(negedge i_ref_clk) begin
    cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
    o_tick <= i_en && (cnt == GAP - 1);
  end
endmodule

/* File: dv/test_stepper_fault_chop.sv */
// Purpose: self-checking bench for the fault and chopper timing block
// Assumes: inputs change on the falling edge, outputs read there too
// Notes: tick gap of 8 cycles keeps the chopper period at 128 cycles
module test_stepper_fault_chop;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 8;
  logic i_ref_clk = 0, i_rst_n = 0, i_standby_n = 1, i_thermal_over = 0, i_over_current = 0, i_sense_over = 0;
  logic i_chop_osc, o_bridge_en, o_chop_on, o_osc_run, o_thermal_trip, o_overcurrent_trip;
  int errors = 0, checks_done = 0, cycles = 0;
  stepper_fault_chop i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_standby_n(i_standby_n),
    .i_chop_osc(i_chop_osc), .i_thermal_over(i_thermal_over), .i_over_current(i_over_current),
    .i_sense_over(i_sense_over), .o_bridge_en(o_bridge_en), .o_chop_on(o_chop_on), .o_osc_run(o_osc_run),
    .o_thermal_trip(o_thermal_trip), .o_overcurrent_trip(o_overcurrent_trip));
  stepper_controller_model #(.GAP(GAP)) i_ctl (.i_ref_clk(i_ref_clk), .i_en(o_osc_run), .o_tick(i_chop_osc));
  initial forever #4 i_ref_clk = ~i_ref_clk;
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      complete_run();
    end
  end
  task automatic check_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic edges(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic wait_ticks(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      while (i_chop_osc !== 1'b1) @(posedge i_ref_clk);
    end
    @(negedge i_ref_clk);
  endtask
  task automatic standby_pulse();
    i_standby_n = 0;
    edges(1);
    check_bit("trips_cleared", 1'b0, o_thermal_trip | o_overcurrent_trip);
    i_standby_n = 1;
    edges(1);
    check_bit("bridge_resumed", 1'b1, o_bridge_en);
  endtask
  task automatic test_thermal();
    i_thermal_over = 1;
    edges(1);
    check_bit("thermal_trip", 1'b1, o_thermal_trip & ~o_bridge_en);
    i_thermal_over = 0;
    edges(20);
    check_bit("thermal_held", 1'b1, o_thermal_trip & ~o_bridge_en);
    standby_pulse();
  endtask
  task automatic test_overcurrent();
    i_over_current = 1;
    wait_ticks(3);
    i_over_current = 0;
    edges(1);
    check_bit("short_ignored", 1'b0, o_overcurrent_trip);
    i_over_current = 1;
    wait_ticks(3);
    check_bit("no_trip_3_ticks", 1'b0, o_overcurrent_trip);
    wait_ticks(1);
    check_bit("trip_4th_tick", 1'b1, o_overcurrent_trip);
    check_bit("off_and_stopped", 1'b0, o_bridge_en | o_osc_run);
    i_over_current = 0;
    i_sense_over = 1;
    edges(200);
    check_bit("trip_held", 1'b1, o_overcurrent_trip);
    check_bit("outputs_idle", 1'b0, o_bridge_en | o_chop_on);
    i_sense_over = 0;
    i_thermal_over = 1;
    edges(1);
    check_bit("thermal_in_oc", 1'b1, o_thermal_trip & o_overcurrent_trip);
    i_thermal_over = 0;
    standby_pulse();
  endtask
  task automatic cycles_to_rise(output int n);
    logic prev;
    n = 0;
    do begin
      prev = o_chop_on;
      edges(1);
      n++;
    end while (!(prev === 1'b0 && o_chop_on === 1'b1) && n < 400);
  endtask
  task automatic test_chop();
    int n;
    standby_pulse();
    i_sense_over = 1;
    edges(37);
    check_bit("chop_blanked", 1'b1, o_chop_on);
    n = 0;
    while (o_chop_on === 1'b1 && n < 30) begin
      edges(1);
      n++;
    end
    check_bit("chop_cut_by_62", 1'b1, n <= 25);
    cycles_to_rise(n);
    cycles_to_rise(n);
    // 16 ticks per period; 1600 kHz in gives 100 kHz out
    check_bit("chop_period", 1'b1, n == stepper_fault_pkg::CHOP_DIV * GAP);
    i_sense_over = 0;
  endtask
  initial begin
    edges(10);
    check_bit("reset_state", 1'b1, ~o_bridge_en & o_osc_run & ~o_chop_on);
    i_rst_n = 1;
    edges(1);
    check_bit("run_entry", 1'b1, o_bridge_en & o_chop_on);
    test_thermal();
    test_overcurrent();
    test_chop();
    complete_run();
  end
endmodule
